// ==== hdl/mxb_pkg.sv ====
// Purpose: shared constants and types of the multiplexed external memory bus
// Assumes: 16-bit program and data spaces, 8-bit data
// Notes:   all figures of the bus live here and nowhere else
package mxb_pkg;

	// ************************************************************
	// widths and address map
	// ************************************************************
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 8;
	localparam int          HALF_W         = 8;
	localparam logic [15:0] ONCHIP_TOP     = 16'h1FFF;
	localparam logic [15:0] OTP_TEST_BASE  = 16'h1FC0;
	localparam logic [7:0]  TEST_AREA_DATA = 8'hFF;
	localparam logic [15:0] VEC_HI_ADDR    = 16'h0000;
	localparam logic [15:0] VEC_LO_ADDR    = 16'h0001;
	localparam logic        SPACE_PROG     = 1'h1;
	localparam logic        SPACE_DATA     = 1'h0;

	// ************************************************************
	// timing counts and buffering
	// ************************************************************
	localparam int          DS_MIN_CYC     = 3;
	localparam int          CNT_W          = 4;
	localparam int          RSP_DEPTH      = 2;
	localparam int          SYNC_W         = 10;

	// ************************************************************
	// bus cycle sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_LATCH = 3'b010,
		ST_SETUP = 3'b011,
		ST_DATA  = 3'b100,
		ST_END   = 3'b101,
		ST_GRANT = 3'b110
	} mxb_state_t;

endpackage : mxb_pkg

// ==== hdl/mxb_strm_if.sv ====
// Purpose: valid/ready word carrier between the bus block's own modules
// Assumes: one clock
// Notes:   a word moves when valid and ready are both high at an edge
`timescale 1ns/100ps
interface mxb_strm_if #(
	parameter int W = 8
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : mxb_strm_if

// ==== hdl/mxb_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
module mxb_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : mxb_sync

// ==== hdl/mxb_buf2.sv ====
// Purpose: small circular buffer for read data heading to the core
// Assumes: one clock, drain side may stall at will
// Notes:   valid and ready are registered so the core sees flop outputs
`timescale 1ns/100ps
module mxb_buf2 #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic ce,
	mxb_strm_if.snk   up,
	mxb_strm_if.src   dn
);
	import mxb_pkg::*;
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [PW-1:0] rd_nxt;
	logic [W-1:0]  out_d_r;
	logic [PW:0]   cnt_r;
	logic [PW:0]   cnt_nxt;
	logic          push;
	logic          pop;
	logic          out_v_r;
	logic          in_rdy_r;

	assign up.ready = in_rdy_r;
	assign dn.valid = out_v_r;
	assign dn.data  = out_d_r;
	assign push     = up.valid & in_rdy_r;
	assign pop      = out_v_r & dn.ready;

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'h1;
		end
	end

	always_comb begin
		rd_nxt = rd_r;
		if (pop) begin
			rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (ce && push) begin
			mem_r[wr_r] <= up.data;
		end
	end

	// ************************************************************
	// pointers and flags; a full buffer drops ready to stall the source
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_r     <= '0;
			rd_r     <= '0;
			cnt_r    <= '0;
			out_v_r  <= 1'h0;
			in_rdy_r <= 1'h0;
			out_d_r  <= '0;
		end else if (ce) begin
			if (push) begin
				wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'h1;
			end
			if (pop) begin
				rd_r <= rd_nxt;
			end
			// head refilled a cycle early so the drain side reads a flop, not a mux
			if (!out_v_r || pop) begin
				out_d_r <= (cnt_r != (PW + 1)'(pop)) ? mem_r[rd_nxt] : up.data;
			end
			cnt_r    <= cnt_nxt;
			out_v_r  <= (cnt_nxt != '0);
			in_rdy_r <= (cnt_nxt != (PW + 1)'(DEPTH));
		end
	end
endmodule : mxb_buf2

// ==== hdl/mxb_bus.sv ====
// Purpose: multiplexed external memory bus of an 8/16-bit controller
// Assumes: core requests on clk_sys; memory pins asynchronous
// Notes:   read data reaches the core through a two-entry buffer
`timescale 1ns/100ps
module mxb_bus #(
	parameter int   DS_MIN      = mxb_pkg::DS_MIN_CYC,
	parameter logic OTP_VARIANT = 1'h0
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_b,
	input  wire logic                       ce,
	input  wire logic                       bus_float,
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire logic                       req_write,
	input  wire logic                       req_space,
	input  wire logic [mxb_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [mxb_pkg::DATA_W-1:0] req_wdata,
	output logic                            rsp_valid,
	input  wire logic                       rsp_ready,
	output logic      [mxb_pkg::DATA_W-1:0] rsp_data,
	output logic      [mxb_pkg::ADDR_W-1:0] boot_vector,
	output logic                            boot_done,
	output logic                            onchip_rd,
	output logic      [mxb_pkg::ADDR_W-1:0] onchip_addr,
	input  wire logic [mxb_pkg::DATA_W-1:0] onchip_rdata,
	output logic                            address_latch_strobe_n,
	output logic                            data_transfer_strobe_n,
	output logic                            read_write_n,
	output logic                            space_select,
	output logic                            strobe_oe_n,
	output logic      [mxb_pkg::HALF_W-1:0] high_address_port,
	output logic      [mxb_pkg::DATA_W-1:0] muxed_addr_data_port,
	input  wire logic [mxb_pkg::DATA_W-1:0] muxed_addr_data_in,
	output logic                            muxed_oe_n,
	input  wire logic                       external_wait_n,
	input  wire logic                       external_bus_request,
	output logic                            external_bus_grant_n
);
	import mxb_pkg::*;

	mxb_state_t          state_r;
	mxb_state_t          state_nxt;
	logic [ADDR_W-1:0]   cyc_addr_r;
	logic [ADDR_W-1:0]   addr_nxt;
	logic [DATA_W-1:0]   cyc_wdata_r;
	logic [DATA_W-1:0]   wdata_nxt;
	logic                cyc_wr_r;
	logic                wr_nxt;
	logic                cyc_space_r;
	logic                space_nxt;
	logic                cyc_int_r;
	logic                int_nxt;
	logic                cyc_boot_r;
	logic                boot_nxt;
	logic                start;
	logic                take;
	logic [CNT_W-1:0]    ds_cnt_r;
	logic                ds_min_done;
	logic [DATA_W-1:0]   rdata_r;
	logic                boot_hi_r;
	logic                ext_act_nxt;
	logic                float_nxt;
	logic                drive_ad_nxt;
	logic [SYNC_W-1:0]   sync_q;
	logic                wait_n_s;
	logic                bus_req_s;
	logic [DATA_W-1:0]   ad_in_s;

	mxb_strm_if #(.W(DATA_W)) rsp_in ();
	mxb_strm_if #(.W(DATA_W)) rsp_out ();

	// ************************************************************
	// pin inputs: two flops before any logic looks at them
	// ************************************************************
	mxb_sync #(.W(SYNC_W)) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ce      (ce),
		.d       ({external_wait_n, external_bus_request, muxed_addr_data_in}),
		.q       (sync_q)
	);
	assign wait_n_s  = sync_q[SYNC_W-1];
	assign bus_req_s = sync_q[SYNC_W-2];
	assign ad_in_s   = sync_q[DATA_W-1:0];

	// ************************************************************
	// address map
	// ************************************************************
	function automatic logic is_onchip(input logic sp, input logic [ADDR_W-1:0] a);
		is_onchip = (sp == SPACE_PROG) && (a <= ONCHIP_TOP);
	endfunction : is_onchip

	assign take        = req_valid & req_ready;
	assign ds_min_done = (ds_cnt_r >= CNT_W'(DS_MIN - 1));

	// ************************************************************
	// cycle sequencer
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		start     = 1'h0;
		addr_nxt  = cyc_addr_r;
		wr_nxt    = cyc_wr_r;
		space_nxt = cyc_space_r;
		wdata_nxt = cyc_wdata_r;
		boot_nxt  = cyc_boot_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take) begin
					start     = 1'h1;
					addr_nxt  = req_addr;
					wr_nxt    = req_write;
					space_nxt = req_space;
					wdata_nxt = req_wdata;
					boot_nxt  = 1'h0;
				end else if (!boot_done) begin
					start     = 1'h1;
					addr_nxt  = boot_hi_r ? VEC_LO_ADDR : VEC_HI_ADDR;
					wr_nxt    = 1'h0;
					space_nxt = SPACE_PROG;
					boot_nxt  = 1'h1;
				end else if (bus_req_s) begin
					state_nxt = ST_GRANT;
				end
				if (start) begin
					state_nxt = ST_ADDR;
				end
			end
			ST_ADDR:  state_nxt = ST_LATCH;
			ST_LATCH: state_nxt = ST_SETUP;
			ST_SETUP: state_nxt = ST_DATA;
			ST_DATA: begin
				if (ds_min_done && (cyc_int_r || wait_n_s)) begin
					state_nxt = ST_END;
				end
			end
			ST_END: begin
				if (cyc_wr_r || cyc_boot_r || rsp_in.ready) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_GRANT: begin
				if (!bus_req_s) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	assign int_nxt      = is_onchip(space_nxt, addr_nxt);
	assign ext_act_nxt  = (state_nxt != ST_IDLE) && (state_nxt != ST_GRANT) && !int_nxt;
	assign float_nxt    = (state_nxt == ST_GRANT) || (bus_float && !ext_act_nxt);
	assign drive_ad_nxt = (state_nxt == ST_ADDR) || (state_nxt == ST_LATCH) ||
		(ext_act_nxt && wr_nxt && (state_nxt != ST_ADDR));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cyc_addr_r  <= '0;
			cyc_wdata_r <= '0;
			cyc_wr_r    <= 1'h0;
			cyc_space_r <= SPACE_PROG;
			cyc_int_r   <= 1'h1;
			cyc_boot_r  <= 1'h0;
		end else if (ce && start) begin
			cyc_addr_r  <= addr_nxt;
			cyc_wdata_r <= wdata_nxt;
			cyc_wr_r    <= wr_nxt;
			cyc_space_r <= space_nxt;
			cyc_int_r   <= int_nxt;
			cyc_boot_r  <= boot_nxt;
		end
	end

	// a slow device may need more than the minimum strobe; wait covers it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ds_cnt_r <= '0;
		end else if (ce) begin
			if (state_r != ST_DATA) begin
				ds_cnt_r <= '0;
			end else if (!ds_min_done) begin
				ds_cnt_r <= ds_cnt_r + 1'h1;
			end
		end
	end

	// ************************************************************
	// read data capture, taken as the data strobe rises
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= '0;
		end else if (ce && (state_r == ST_DATA) && (state_nxt == ST_END)) begin
			if (!cyc_int_r) begin
				rdata_r <= ad_in_s;
			end else if (OTP_VARIANT && (cyc_addr_r >= OTP_TEST_BASE)) begin
				rdata_r <= TEST_AREA_DATA;
			end else begin
				rdata_r <= onchip_rdata;
			end
		end
	end

	// ************************************************************
	// start vector: byte 00h is the high half
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			boot_hi_r   <= 1'h0;
			boot_done   <= 1'h0;
			boot_vector <= '0;
		end else if (ce && (state_r == ST_END) && cyc_boot_r) begin
			if (!boot_hi_r) begin
				boot_vector[ADDR_W-1:HALF_W] <= rdata_r;
				boot_hi_r                    <= 1'h1;
			end else begin
				boot_vector[HALF_W-1:0] <= rdata_r;
				boot_done               <= 1'h1;
			end
		end
	end

	// core may only issue while idle, booted and not floated
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_ready <= 1'h0;
		end else if (ce) begin
			req_ready <= (state_nxt == ST_IDLE) && boot_done && !bus_req_s && !bus_float;
		end
	end

	// ************************************************************
	// on-chip store port
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			onchip_rd   <= 1'h0;
			onchip_addr <= '0;
		end else if (ce) begin
			onchip_rd   <= (state_nxt == ST_ADDR) && int_nxt && !wr_nxt;
			onchip_addr <= addr_nxt;
		end
	end

	// ************************************************************
	// memory pins, all registered from the next state
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			address_latch_strobe_n <= 1'h1;
			data_transfer_strobe_n <= 1'h1;
			read_write_n           <= 1'h1;
			space_select           <= SPACE_PROG;
			high_address_port      <= '0;
			muxed_addr_data_port   <= '0;
		end else if (ce) begin
			address_latch_strobe_n <= (state_nxt != ST_ADDR);
			data_transfer_strobe_n <= !((state_nxt == ST_DATA) && !int_nxt);
			read_write_n           <= !(ext_act_nxt && wr_nxt);
			space_select           <= space_nxt;
			high_address_port      <= addr_nxt[ADDR_W-1:HALF_W];
			if ((state_nxt == ST_ADDR) || (state_nxt == ST_LATCH)) begin
				muxed_addr_data_port <= addr_nxt[HALF_W-1:0];
			end else begin
				muxed_addr_data_port <= wdata_nxt;
			end
		end
	end

	// address is released before the strobe falls on a read
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strobe_oe_n          <= 1'h1;
			muxed_oe_n           <= 1'h1;
			external_bus_grant_n <= 1'h1;
		end else if (ce) begin
			strobe_oe_n          <= float_nxt;
			muxed_oe_n           <= float_nxt || !drive_ad_nxt;
			external_bus_grant_n <= (state_nxt != ST_GRANT);
		end
	end

	// ************************************************************
	// read data to the core
	// ************************************************************
	assign rsp_in.valid  = (state_r == ST_END) && !cyc_wr_r && !cyc_boot_r;
	assign rsp_in.data   = rdata_r;
	assign rsp_out.ready = rsp_ready;
	assign rsp_valid     = rsp_out.valid;
	assign rsp_data      = rsp_out.data;

	mxb_buf2 #(.W(DATA_W), .DEPTH(RSP_DEPTH)) u_rsp_buf (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ce      (ce),
		.up      (rsp_in),
		.dn      (rsp_out)
	);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys iff ce);
	endclocking
	default disable iff (!rst_b);

	sequence s_as_pulse;
		$fell(address_latch_strobe_n) ##1 address_latch_strobe_n;
	endsequence

	sequence s_ds_fall_write;
		$fell(data_transfer_strobe_n) && !read_write_n;
	endsequence

	a_as_one_pulse: assert property ($fell(address_latch_strobe_n) |-> s_as_pulse)
		else $error("address strobe low for more than one cycle");
	a_addr_at_rise: assert property ($rose(address_latch_strobe_n) |->
		muxed_addr_data_port == cyc_addr_r[HALF_W-1:0] && !muxed_oe_n &&
		high_address_port == cyc_addr_r[ADDR_W-1:HALF_W] && space_select == cyc_space_r)
		else $error("address not valid at address strobe rise");
	a_float_group: assert property (strobe_oe_n |-> muxed_oe_n)
		else $error("muxed port driven while strobes float");
	a_float_idle: assert property (state_r == ST_IDLE && bus_float && !take |=>
		strobe_oe_n && muxed_oe_n)
		else $error("bus pins still driven while floated and idle");
	a_wdata_lead: assert property (s_ds_fall_write |->
		!muxed_oe_n && $past(!muxed_oe_n) && muxed_addr_data_port == cyc_wdata_r)
		else $error("write data late for data strobe");
	a_ds_onchip: assert property (cyc_int_r && state_r != ST_IDLE |-> data_transfer_strobe_n)
		else $error("data strobe active on on-chip access");
	a_rw_ext_write: assert property (!read_write_n |-> cyc_wr_r && !cyc_int_r)
		else $error("direction low outside an external write");
	a_boot_addr: assert property (!boot_done && !address_latch_strobe_n |->
		high_address_port == 8'h00 && space_select == SPACE_PROG)
		else $error("start vector fetched from wrong place");
	a_ext_fetch: assert property (take && req_space == SPACE_PROG
		&& req_addr > ONCHIP_TOP |=> !cyc_int_r ##3 !data_transfer_strobe_n)
		else $error("fetch above on-chip store did not go external");
	a_wait_holds: assert property (state_r == ST_DATA && !cyc_int_r && !wait_n_s
		|=> !data_transfer_strobe_n)
		else $error("data strobe released while wait held");
	a_grant_float: assert property (!external_bus_grant_n |-> strobe_oe_n && muxed_oe_n)
		else $error("bus granted but pins still driven");
endmodule : mxb_bus

// ==== verif/mxb_mem_model.sv ====
// Purpose: external program and data memory on the multiplexed bus
// Assumes: address and space are latched as the address strobe rises; direction is read live
// Notes:   a released data line shows the inverted last value, resolved in the bench
`timescale 1ns/100ps
module mxb_mem_model (
	input  wire logic       clk_sys,
	input  wire logic       as_n,
	input  wire logic       ds_n,
	input  wire logic       rw_n,
	input  wire logic       space,
	input  wire logic [7:0] hi,
	input  wire logic [7:0] lo,
	input  wire logic [7:0] wait_cyc,
	output logic            wait_n,
	output logic            drv,
	output logic      [7:0] dout
);
	logic [7:0]  mem [bit [16:0]];
	logic [16:0] a_r;
	int          w_r;

	function automatic logic [7:0] init_val(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ {a[16], 7'h5A};
	endfunction : init_val

	initial begin
		wait_n = 1'h1;
		drv = 1'h0;
		dout = 8'h00;
		w_r = 0;
	end
	always @(posedge as_n) begin
		a_r = {space, hi, lo};
	end
	// a slow memory holds wait low from the address phase on
	always @(posedge clk_sys) begin
		w_r = !as_n ? wait_cyc : (w_r > 0 ? w_r - 1 : 0);
		wait_n <= (w_r == 0);
		if (!ds_n && !rw_n) begin
			mem[a_r] = lo;
		end
	end
	always @(negedge ds_n) begin
		if (rw_n) begin
			dout = mem.exists(a_r) ? mem[a_r] : init_val(a_r);
			drv = 1'h1;
		end
	end
	// held one clock past the strobe rise, then let go
	always @(posedge ds_n) begin
		@(posedge clk_sys);
		drv = 1'h0;
	end
endmodule : mxb_mem_model

// ==== verif/mux_external_memory_bus_bench.sv ====
// Purpose: self-checking bench of the multiplexed external memory bus
// Assumes: default strobe length, non-OTP part, clock enable held high
// Notes:   on-chip store and external memory are modelled here
`timescale 1ns/100ps
module mux_external_memory_bus_bench;
	import mxb_pkg::*;
	typedef struct {logic w; logic s; logic [15:0] a; logic [7:0] d; logic [7:0] e;} mxb_row_t;
	logic        clk_sys = 1'h0, rst_b, bus_float, req_valid, req_write, req_space, rsp_ready;
	logic [15:0] req_addr, boot_vector, onchip_addr;
	logic [7:0]  req_wdata, rsp_data, onchip_rdata, hi, lo, pin, dout, last_r;
	logic        req_ready, rsp_valid, boot_done, onchip_rd, as_n, ds_n, rw_n, space, soe_n;
	logic        moe_n, wait_n, breq, gnt_n, drv;
	logic [16:0] ds_lo, rw_lo, as_lo, rd_lo;
	logic [7:0]  wcyc = 8'h00;
	int          bad_count = 0, compares = 0;
	logic [7:0]  rq[$];
	mxb_row_t    rows[10];

	mxb_bus #(.DS_MIN(DS_MIN_CYC)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'h1),
		.bus_float(bus_float), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_space(req_space), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
		.rsp_data(rsp_data), .boot_vector(boot_vector), .boot_done(boot_done),
		.onchip_rd(onchip_rd), .onchip_addr(onchip_addr), .onchip_rdata(onchip_rdata),
		.address_latch_strobe_n(as_n), .data_transfer_strobe_n(ds_n), .read_write_n(rw_n),
		.space_select(space), .strobe_oe_n(soe_n), .high_address_port(hi),
		.muxed_addr_data_port(lo), .muxed_addr_data_in(pin), .muxed_oe_n(moe_n),
		.external_wait_n(wait_n), .external_bus_request(breq), .external_bus_grant_n(gnt_n));
	mxb_mem_model mem (.clk_sys(clk_sys), .as_n(as_n), .ds_n(ds_n), .rw_n(rw_n),
		.space(space), .hi(hi), .lo(pin), .wait_cyc(wcyc), .wait_n(wait_n), .drv(drv),
		.dout(dout));

	// ************************************************************
	// pin resolution, on-chip store, monitors
	// ************************************************************
	assign pin = !moe_n ? lo : (drv ? dout : ~last_r);
	always #10 clk_sys = ~clk_sys;
	always @(negedge clk_sys) onchip_rdata <= rom(onchip_addr);
	always @(posedge clk_sys) begin
		last_r <= pin;
		if (rsp_valid && rsp_ready) rq.push_back(rsp_data);
		if (!ds_n) ds_lo++;
		if (!rw_n) rw_lo++;
		if (!as_n) as_lo++;
		if (onchip_rd) rd_lo++;
	end

	function automatic logic [7:0] rom(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hC3;
	endfunction : rom

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// watches the grant pin itself; a copied argument would never change
	task automatic settle(input logic lvl);
		int n;
		n = 0;
		while (gnt_n !== lvl && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 200) bad_count++;
	endtask : settle

	task automatic complete_run();
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic rst_seq();
		rst_b <= 1'h0;
		repeat (2) @(negedge clk_sys);
		chk(17'(as_n & soe_n & moe_n & gnt_n), 17'h1);
		rst_b <= 1'h1;
		repeat (30) @(negedge clk_sys);
		chk(17'(boot_done), 17'h1);
		chk({1'h0, boot_vector}, {1'h0, rom(VEC_HI_ADDR), rom(VEC_LO_ADDR)});
	endtask : rst_seq

	task automatic op(input mxb_row_t r);
		logic io;
		int   n;
		io = r.s && (r.a <= ONCHIP_TOP);
		n = 0;
		while (req_ready !== 1'h1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		ds_lo = '0;
		rw_lo = '0;
		as_lo = '0;
		rd_lo = '0;
		{req_write, req_space, req_addr, req_wdata, req_valid} <= {r.w, r.s, r.a, r.d, 1'h1};
		@(negedge clk_sys);
		req_valid <= 1'h0;
		repeat (2) @(negedge clk_sys);
		n = 0;
		while (!(req_ready === 1'h1 && (r.w || rq.size() > 0 || !rsp_ready)) && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 200) bad_count++;
		chk(as_lo, 17'h1);
		chk(17'(ds_lo == 0), 17'(io));
		chk(17'(rw_lo != 0), 17'(r.w && !io));
		chk(rd_lo, 17'(io && !r.w));
		if (!io) chk(mem.a_r, {r.s, r.a});
		if (!r.w && rsp_ready) chk({9'h0, rq.pop_front()}, {9'h0, r.e});
	endtask : op

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{rst_b, bus_float, req_valid, req_write, req_space, breq} = '0;
		{req_addr, req_wdata, last_r} = '0;
		rsp_ready = 1'h1;
		onchip_rdata = 8'h00;
		rows = '{'{0, 1, 16'h0100, 0, rom(16'h0100)}, '{0, 1, 16'h1FFF, 0, rom(16'h1FFF)},
			'{0, 1, 16'h2000, 0, mem.init_val(17'h12000)},
			'{0, 0, 16'h0100, 0, mem.init_val(17'h00100)},
			'{1, 0, 16'h0200, 8'hA5, 0}, '{0, 0, 16'h0200, 0, 8'hA5},
			'{1, 1, 16'hFF00, 8'h5A, 0}, '{0, 1, 16'hFF00, 0, 8'h5A},
			'{1, 1, 16'h0010, 8'h77, 0}, '{0, 1, 16'h0010, 0, rom(16'h0010)}};
		rst_seq();
		foreach (rows[i]) op(rows[i]);
		// slow memory stretches the strobe beyond its minimum
		wcyc = 8'h06;
		op('{0, 0, 16'h0300, 0, mem.init_val(17'h00300)});
		chk(17'(ds_lo > 4), 17'h1);
		wcyc = 8'h00;
		// stalled consumer: both words kept, handed over in order
		rsp_ready <= 1'h0;
		op('{0, 1, 16'hC001, 0, 0});
		op('{0, 1, 16'h0005, 0, 0});
		chk(17'(rsp_valid), 17'h1);
		rsp_ready <= 1'h1;
		repeat (4) @(negedge clk_sys);
		chk({9'h0, rq.pop_front()}, {9'h0, mem.init_val(17'h1C001)});
		chk({9'h0, rq.pop_front()}, {9'h0, rom(16'h0005)});
		// bus handed to another master, then taken back
		breq <= 1'h1;
		settle(1'h0);
		chk(17'({soe_n, moe_n, req_ready}), 17'h6);
		breq <= 1'h0;
		settle(1'h1);
		chk(17'({soe_n, gnt_n}), 17'h1);
		// software float releases the strobe group and the muxed port together
		bus_float <= 1'h1;
		repeat (3) @(negedge clk_sys);
		chk(17'({soe_n, moe_n, req_ready}), 17'h6);
		bus_float <= 1'h0;
		// reset again in mid-run: vector fetched afresh
		rst_seq();
		op(rows[2]);
		complete_run();
	end

	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
endmodule : mux_external_memory_bus_bench
